//--- qdac_chan_bank.sv
// Channel register bank: input and output registers with pending flags.
`include "qdac_defs.svh"

module qdac_chan_bank
	import qdac_pkg::*;
(
	// Clock and reset.
	input  wire logic                         clock,
	input  wire logic                         srst,
	// Write port.
	input  wire logic                         wrEn,
	input  wire logic [`QDAC_CHANS-1:0]       wrMask,
	input  wire qdac_word_t                   wrData,
	input  wire logic                         wrNow,
	// Load and clear.
	input  wire logic                         loadAll,
	input  wire logic                         clearAll,
	// Read port.
	input  wire logic [`QDAC_CHAN_W-1:0]      rdChan,
	output qdac_word_t                        rdData,
	// Channel state.
	output wire logic [`QDAC_CHANS-1:0][15:0] chanValue,
	output wire logic [`QDAC_CHANS-1:0]       pendMask
);

	qdac_word_t inVec [`QDAC_CHANS];

	// --------------------------------------------------------------------
	// Per-channel registers
	// --------------------------------------------------------------------
	genvar i;
	generate
		for (i = 0; i < `QDAC_CHANS; i++) begin : g_chan
			qdac_word_t inReg;
			qdac_word_t outReg;
			logic       pend;

			// Clear beats a write, and a write beats a load on its own channel.
			always_ff @(posedge clock) begin
				if (srst || clearAll) begin
					inReg  <= `QDAC_CLEAR_VAL;
					outReg <= `QDAC_CLEAR_VAL;
					pend   <= 1'b0;
				end else if (wrEn && wrMask[i]) begin
					inReg <= wrData;
					pend  <= !wrNow;
					if (wrNow) begin
						outReg <= wrData;
					end
				end else if (loadAll && pend) begin
					outReg <= inReg;
					pend   <= 1'b0;
				end
			end

			assign inVec[i]     = inReg;
			assign chanValue[i] = outReg;
			assign pendMask[i]  = pend;
		end
	endgenerate

	// Read data comes from a register so the caller gets it one cycle later.
	always_ff @(posedge clock) begin
		if (srst) begin
			rdData <= `QDAC_CLEAR_VAL;
		end else begin
			rdData <= inVec[rdChan];
		end
	end

endmodule : qdac_chan_bank

//--- qdac_defs.svh
// Constants for the four-channel converter serial load control.
`ifndef QDAC_DEFS_SVH
`define QDAC_DEFS_SVH

// ----------------------------------------------------------------------------
// Sizes
// ----------------------------------------------------------------------------
`define QDAC_WORD_W      24
`define QDAC_DATA_W      16
`define QDAC_CHANS       4
`define QDAC_CHAN_W      2
`define QDAC_CNT_W       5
`define QDAC_CNT_FULL    5'h18
`define QDAC_CNT_OVER    5'h19
`define QDAC_CNT_ZERO    5'h00
`define QDAC_CNT_ONE     5'h01

// ----------------------------------------------------------------------------
// Serial word layout
// ----------------------------------------------------------------------------
`define QDAC_RD_BIT      23
`define QDAC_SEL_HI      22
`define QDAC_SEL_LO      19
`define QDAC_ADDR_HI     18
`define QDAC_ADDR_LO     16
`define QDAC_SEL_DATA    4'h0
`define QDAC_SEL_FUNC    4'h1
`define QDAC_ADDR_ALL    3'h4
`define QDAC_RB_PAD      8'h00

// ----------------------------------------------------------------------------
// Function register layout
// ----------------------------------------------------------------------------
`define QDAC_FN_W        5
`define QDAC_FN_DAISY    0
`define QDAC_FN_GP_BASE  1
`define QDAC_FN_RESET    5'h00
`define QDAC_GP_PINS     2
`define QDAC_RB_FILL     9'h000

// ----------------------------------------------------------------------------
// Input synchroniser lanes
// ----------------------------------------------------------------------------
`define QDAC_SI_W        7
`define QDAC_SI_FRAME    0
`define QDAC_SI_SCLK     1
`define QDAC_SI_SERIAL_DATA_IN     2
`define QDAC_SI_CLR      3
`define QDAC_SI_LOAD     4
`define QDAC_SI_GP       5
`define QDAC_SI_IDLE     7'h7f

`define QDAC_CLEAR_VAL   16'h0000

`endif

//--- qdac_host_model.sv
// Host model that drives the serial link of the four-channel converter control.
module qdac_host_model (
	// Serial link towards the device.
	output logic      frameSelN,
	output logic      serialClk,
	output logic      serialDataIn,
	input  wire logic serialDataOut
);
	timeunit 1ns;
	timeprecision 100ps;

	// ------------------------------------------------------------------------
	// Link timing
	// ------------------------------------------------------------------------
	// A 48 ns period keeps the link well below its top rate.
	localparam int HALF_NS = 24;

	// The link idles with select high and the serial clock parked high.
	initial begin
		frameSelN    = 1'b1;
		serialClk    = 1'b1;
		serialDataIn = 1'b0;
	end

	// ------------------------------------------------------------------------
	// One frame
	// ------------------------------------------------------------------------
	// Sends nBits MSB first and collects the data out line just before each
	// falling clock edge, where the device has had a whole half period to settle.
	task automatic xfer(input logic [23:0] word, input int nBits, output logic [23:0] seen);
		logic [23:0] sh;
		sh   = word;
		seen = 24'h000000;
		frameSelN <= 1'b0;
		for (int i = 0; i < nBits; i++) begin
			serialDataIn <= sh[23];
			sh = {sh[22:0], sh[23]};
			#HALF_NS;
			seen = {seen[22:0], serialDataOut};
			serialClk <= 1'b0;
			#HALF_NS;
			serialClk <= 1'b1;
		end
		#HALF_NS;
		frameSelN <= 1'b1;
		// The released data line flips so that no stale bit can be mistaken for data.
		serialDataIn <= ~serialDataIn;
		#(8 * HALF_NS);
	endtask : xfer

	// Pulses the serial clock with the frame deselected; no bit may be taken.
	task automatic stray(input int nClk);
		for (int i = 0; i < nClk; i++) begin
			#HALF_NS;
			serialClk <= 1'b0;
			#HALF_NS;
			serialClk <= 1'b1;
		end
		#(8 * HALF_NS);
	endtask : stray

endmodule : qdac_host_model

//--- qdac_pkg.sv
// Types shared by the serial load control design.
package qdac_pkg;

	// --------------------------------------------------------------------
	// Frame tracking
	// --------------------------------------------------------------------
	typedef enum logic {
		FR_IDLE,
		FR_SHIFT
	} qdac_frame_t;

	typedef logic [15:0] qdac_word_t;

endpackage : qdac_pkg

//--- qdac_serial_ctrl.sv
// Serial load control for a four-channel voltage-output converter.
`include "qdac_defs.svh"

module qdac_serial_ctrl
	import qdac_pkg::*;
(
	// Clock and reset.
	input  wire logic                         clock,
	input  wire logic                         srst,
	// Serial link.
	input  wire logic                         frameSelN,
	input  wire logic                         serialClk,
	input  wire logic                         serialDataIn,
	output logic                              serialDataOut,
	// Load control.
	input  wire logic                         clearN,
	input  wire logic                         loadStrobeN,
	// General-purpose pins.
	input  wire logic [`QDAC_GP_PINS-1:0]     gpPinIn,
	output logic      [`QDAC_GP_PINS-1:0]     gpPinOut,
	output logic      [`QDAC_GP_PINS-1:0]     gpPinOe,
	// Channel outputs.
	output wire logic [`QDAC_CHANS-1:0][15:0] chanValue
);

	// --------------------------------------------------------------------
	// Decoding helpers
	// --------------------------------------------------------------------
	// An address at or above the all-channels code selects every channel.
	function automatic logic [`QDAC_CHANS-1:0] chanMask(input logic [2:0] addr);
		logic [`QDAC_CHANS-1:0] m;
		m = '0;
		if (addr >= `QDAC_ADDR_ALL) begin
			m = '1;
		end else begin
			m[addr[`QDAC_CHAN_W-1:0]] = 1'b1;
		end
		return m;
	endfunction : chanMask

	// --------------------------------------------------------------------
	// Input synchronisers
	// --------------------------------------------------------------------
	logic [`QDAC_SI_W-1:0] syncA;
	logic [`QDAC_SI_W-1:0] syncB;
	logic [`QDAC_SI_W-1:0] syncPrev;
	wire  [`QDAC_SI_W-1:0] pinsRaw = {gpPinIn, loadStrobeN, clearN, serialDataIn,
	                                  serialClk, frameSelN};

	// Lanes reset high: an open clear or an open pin input must look idle.
	always_ff @(posedge clock) begin
		if (srst) begin
			syncA    <= `QDAC_SI_IDLE;
			syncB    <= `QDAC_SI_IDLE;
			syncPrev <= `QDAC_SI_IDLE;
		end else begin
			syncA    <= pinsRaw;
			syncB    <= syncA;
			syncPrev <= syncB;
		end
	end

	// Edges are found from the second stage against its own delayed copy.
	wire frameActive = !syncB[`QDAC_SI_FRAME];
	wire frameFall   = syncPrev[`QDAC_SI_FRAME] && !syncB[`QDAC_SI_FRAME];
	wire frameRise   = !syncPrev[`QDAC_SI_FRAME] && syncB[`QDAC_SI_FRAME];
	wire sclkFall    = syncPrev[`QDAC_SI_SCLK] && !syncB[`QDAC_SI_SCLK];
	wire sclkRise    = !syncPrev[`QDAC_SI_SCLK] && syncB[`QDAC_SI_SCLK];
	wire dataBit     = syncB[`QDAC_SI_SERIAL_DATA_IN];
	wire clearFall   = syncPrev[`QDAC_SI_CLR] && !syncB[`QDAC_SI_CLR];
	wire loadFall    = syncPrev[`QDAC_SI_LOAD] && !syncB[`QDAC_SI_LOAD];
	wire loadLow     = !syncB[`QDAC_SI_LOAD];
	wire [`QDAC_GP_PINS-1:0] gpLevel = syncB[`QDAC_SI_GP +: `QDAC_GP_PINS];

	// --------------------------------------------------------------------
	// Frame state and shift register
	// --------------------------------------------------------------------
	qdac_frame_t                     frameState;
	qdac_frame_t                     next_frameState;
	logic [`QDAC_CNT_W-1:0]          bitCount;
	logic [`QDAC_WORD_W-1:0]         shiftReg;
	logic [`QDAC_FN_W-1:0]           fnReg;
	logic                            readPending;
	logic                            loadReadback;
	logic                            readbackFunc;
	qdac_word_t                      bankRdData;
	logic [`QDAC_CHANS-1:0]          pendMask;

	// Taking a bit needs the frame low; a stray clock between frames is ignored.
	wire shiftNow  = (frameState == FR_SHIFT) && frameActive && sclkFall;
	// Anything other than exactly 24 bits is dropped without effect.
	wire complete  = (frameState == FR_SHIFT) && frameRise
	                 && (bitCount == `QDAC_CNT_FULL);
	wire cmdRead   = shiftReg[`QDAC_RD_BIT];
	wire [3:0] cmdSel  = shiftReg[`QDAC_SEL_HI:`QDAC_SEL_LO];
	wire [2:0] cmdAddr = shiftReg[`QDAC_ADDR_HI:`QDAC_ADDR_LO];
	wire wrData    = complete && !cmdRead && (cmdSel == `QDAC_SEL_DATA);
	wire wrFunc    = complete && !cmdRead && (cmdSel == `QDAC_SEL_FUNC);
	wire rdCmd     = complete && cmdRead;
	wire outEnable = fnReg[`QDAC_FN_DAISY] || readPending;
	wire [`QDAC_CHANS-1:0] wrMask = chanMask(cmdAddr);

	// Frame state follows the synchronised frame select.
	always_comb begin
		next_frameState = frameState;
		unique case (frameState)
			FR_IDLE: begin
				if (frameFall) begin
					next_frameState = FR_SHIFT;
				end
			end
			FR_SHIFT: begin
				if (frameRise) begin
					next_frameState = FR_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			frameState <= FR_IDLE;
		end else begin
			frameState <= next_frameState;
		end
	end

	// Bit counter saturates one past a full word so long frames are refused.
	always_ff @(posedge clock) begin
		if (srst || frameFall) begin
			bitCount <= `QDAC_CNT_ZERO;
		end else if (shiftNow && bitCount != `QDAC_CNT_OVER) begin
			bitCount <= bitCount + `QDAC_CNT_ONE;
		end
	end

	// The shift register keeps its contents across frames for daisy-chaining.
	always_ff @(posedge clock) begin
		if (srst) begin
			shiftReg <= '0;
		end else if (loadReadback) begin
			shiftReg <= {`QDAC_RB_PAD, readbackFunc
			             ? {`QDAC_RB_FILL, gpLevel, fnReg} : bankRdData};
		end else if (shiftNow) begin
			shiftReg <= {shiftReg[`QDAC_WORD_W-2:0], dataBit};
		end
	end

	// --------------------------------------------------------------------
	// Readback and serial data out
	// --------------------------------------------------------------------
	// The readback word is loaded one cycle after the read frame, once the
	// bank's registered read data has settled.
	always_ff @(posedge clock) begin
		if (srst) begin
			loadReadback <= 1'b0;
			readbackFunc <= 1'b0;
			readPending  <= 1'b0;
		end else begin
			loadReadback <= rdCmd;
			readbackFunc <= cmdSel == `QDAC_SEL_FUNC;
			if (rdCmd) begin
				readPending <= 1'b1;
			end else if (frameRise) begin
				readPending <= 1'b0;
			end
		end
	end

	// Data out changes on the rising serial clock, so it is stable at the
	// host's sampling edge; it reads zero when neither mode is on.
	always_ff @(posedge clock) begin
		if (srst) begin
			serialDataOut <= 1'b0;
		end else if (!outEnable) begin
			serialDataOut <= 1'b0;
		end else if (frameFall || (frameActive && sclkRise)) begin
			serialDataOut <= shiftReg[`QDAC_RD_BIT];
		end
	end

	// --------------------------------------------------------------------
	// Function register and general-purpose pins
	// --------------------------------------------------------------------
	always_ff @(posedge clock) begin
		if (srst) begin
			fnReg <= `QDAC_FN_RESET;
		end else if (wrFunc) begin
			fnReg <= shiftReg[`QDAC_FN_W-1:0];
		end
	end

	// Each pin takes a direction bit and a value bit from the function word.
	// An input pin is simply not driven; unless the board drives it, the pad pull-up makes it read high.
	genvar g;
	generate
		for (g = 0; g < `QDAC_GP_PINS; g++) begin : g_gp
			always_ff @(posedge clock) begin
				if (srst) begin
					gpPinOe[g]  <= 1'b0;
					gpPinOut[g] <= 1'b0;
				end else begin
					gpPinOe[g]  <= fnReg[`QDAC_FN_GP_BASE + 2*g];
					gpPinOut[g] <= fnReg[`QDAC_FN_GP_BASE + 2*g + 1];
				end
			end
		end
	endgenerate

	// --------------------------------------------------------------------
	// Channel registers
	// --------------------------------------------------------------------
	// Load strobe level decides immediate or deferred update; its fall moves
	// every pending word at once.
	qdac_chan_bank u_bank (
		.clock     (clock),
		.srst      (srst),
		.wrEn      (wrData),
		.wrMask    (wrMask),
		.wrData    (shiftReg[`QDAC_DATA_W-1:0]),
		.wrNow     (loadLow),
		.loadAll   (loadFall),
		.clearAll  (clearFall),
		.rdChan    (cmdAddr[`QDAC_CHAN_W-1:0]),
		.rdData    (bankRdData),
		.chanValue (chanValue),
		.pendMask  (pendMask)
	);

	// --------------------------------------------------------------------
	// Checks
	// --------------------------------------------------------------------
	chk_frame_gate: assert property (
		@(posedge clock) disable iff (srst)
		(sclkFall && !frameActive) |=> $stable(bitCount))
		else $error("Bit counted outside a frame.");

	chk_shift_in: assert property (
		@(posedge clock) disable iff (srst)
		shiftNow && !loadReadback |=> shiftReg[0] == $past(dataBit)
		&& shiftReg[`QDAC_WORD_W-1:1] == $past(shiftReg[`QDAC_WORD_W-2:0]))
		else $error("Serial bit not shifted in.");

	chk_out_bit: assert property (
		@(posedge clock) disable iff (srst)
		(sclkRise && frameActive && outEnable)
		|=> serialDataOut == $past(shiftReg[`QDAC_RD_BIT]))
		else $error("Data out does not follow shift register.");

	chk_clear_zero: assert property (
		@(posedge clock) disable iff (srst)
		clearFall |=> (chanValue == '0) && (pendMask == '0))
		else $error("Clear did not zero the channels.");

	chk_clear_idle: assert property (
		@(posedge clock)
		$fell(srst) |-> !clearFall ##1 !clearFall)
		else $error("Clear fired with no falling edge.");

	chk_load_now: assert property (
		@(posedge clock) disable iff (srst)
		(wrData && loadLow && wrMask[0] && !clearFall)
		|=> chanValue[0] == $past(shiftReg[15:0]) && !pendMask[0])
		else $error("Immediate update missed.");

	chk_load_hold: assert property (
		@(posedge clock) disable iff (srst)
		(wrData && !loadLow && !clearFall)
		|=> $stable(chanValue) && ((pendMask & $past(wrMask)) == $past(wrMask)))
		else $error("Deferred write changed the output.");

	chk_load_all: assert property (
		@(posedge clock) disable iff (srst)
		(loadFall && !wrData && !clearFall) |=> pendMask == '0)
		else $error("Load strobe left channels pending.");

	chk_gp_drive: assert property (
		@(posedge clock) disable iff (srst)
		wrFunc |=> ##1 gpPinOe[0] == $past(shiftReg[1], 2)
		&& gpPinOut[1] == $past(shiftReg[4], 2))
		else $error("Pin setting not applied.");

	chk_count_exact: assert property (
		@(posedge clock) disable iff (srst)
		(frameRise && bitCount != `QDAC_CNT_FULL) |-> !wrData ##1 $stable(fnReg))
		else $error("Short or long frame acted on.");

endmodule : qdac_serial_ctrl

//--- tb.sv
// Self-checking testbench for the serial load control.
module tb;
	timeunit 1ns;
	timeprecision 100ps;

	// ------------------------------------------------------------------------
	// Signals
	// ------------------------------------------------------------------------
	logic                clock;
	logic                srst;
	logic                clearN;
	logic                loadStrobeN;
	logic [1:0]          extEn;
	logic [1:0]          extVal;
	wire                 frameSelN;
	wire                 serialClk;
	wire                 serialDataIn;
	logic                serialDataOut;
	logic [1:0]          gpPinOut;
	logic [1:0]          gpPinOe;
	wire  [1:0]          gpPinIn;
	wire  [3:0][15:0]    chanValue;
	logic [23:0]         rd;
	int                  nFail;
	int                  nTests;

	// Pad level: the device, else the board, else the pull-up.
	assign gpPinIn[0] = gpPinOe[0] ? gpPinOut[0] : (extEn[0] ? extVal[0] : 1'b1);
	assign gpPinIn[1] = gpPinOe[1] ? gpPinOut[1] : (extEn[1] ? extVal[1] : 1'b1);

	qdac_serial_ctrl i_dut (
		.clock        (clock),
		.srst         (srst),
		.frameSelN    (frameSelN),
		.serialClk    (serialClk),
		.serialDataIn (serialDataIn),
		.serialDataOut(serialDataOut),
		.clearN       (clearN),
		.loadStrobeN  (loadStrobeN),
		.gpPinIn      (gpPinIn),
		.gpPinOut     (gpPinOut),
		.gpPinOe      (gpPinOe),
		.chanValue    (chanValue)
	);

	qdac_host_model i_host (
		.frameSelN    (frameSelN),
		.serialClk    (serialClk),
		.serialDataIn (serialDataIn),
		.serialDataOut(serialDataOut)
	);

	// ------------------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------------------
	function automatic logic [23:0] cmd(input logic r, input logic [3:0] s, input logic [2:0] c,
			input logic [15:0] d);
		return {r, s, c, d};
	endfunction : cmd

	task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
		nTests++;
		if (got !== exp) begin
			nFail++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	// Frame end takes about four clocks to land; eight leaves margin.
	task automatic settle;
		repeat (8) @(posedge clock);
	endtask : settle

	task automatic finish_test;
		$display("checks %0d mismatches %0d", nTests, nFail);
		if (nFail == 0 && nTests > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : finish_test

	// ------------------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------------------
	task automatic t_immediate;
		@(posedge clock);
		loadStrobeN <= 1'b0;
		i_host.xfer(cmd(1'b0, 4'h0, 3'h0, 16'h1234), 24, rd);
		settle();
		chk("ch0 after frame", 24'h001234, {8'h00, chanValue[0]});
		chk("ch1 untouched", 24'h000000, {8'h00, chanValue[1]});
	endtask : t_immediate

	task automatic t_deferred;
		@(posedge clock);
		loadStrobeN <= 1'b1;
		i_host.xfer(cmd(1'b0, 4'h0, 3'h1, 16'habcd), 24, rd);
		i_host.xfer(cmd(1'b0, 4'h0, 3'h2, 16'h5a5a), 24, rd);
		settle();
		chk("ch1 held", 24'h000000, {8'h00, chanValue[1]});
		chk("ch2 held", 24'h000000, {8'h00, chanValue[2]});
		@(posedge clock);
		loadStrobeN <= 1'b0;
		// Both pending channels must change in the very same cycle.
		for (int i = 0; i < 10; i++) begin
			@(posedge clock);
			#1;
			chk("ch1 with ch2", {23'h0, chanValue[1] === 16'h0}, {23'h0, chanValue[2] === 16'h0});
		end
		chk("ch1 loaded", 24'h00abcd, {8'h00, chanValue[1]});
		chk("ch2 loaded", 24'h005a5a, {8'h00, chanValue[2]});
		chk("ch0 kept", 24'h001234, {8'h00, chanValue[0]});
	endtask : t_deferred

	task automatic t_refused;
		i_host.xfer(cmd(1'b0, 4'h0, 3'h0, 16'h7777), 23, rd);
		i_host.xfer(cmd(1'b0, 4'h0, 3'h0, 16'h7777), 25, rd);
		i_host.stray(4);
		settle();
		chk("ch0 after odd frames", 24'h001234, {8'h00, chanValue[0]});
	endtask : t_refused

	task automatic t_readback;
		i_host.xfer(cmd(1'b1, 4'h0, 3'h0, 16'h0000), 24, rd);
		i_host.xfer(cmd(1'b1, 4'h0, 3'h0, 16'h0000), 24, rd);
		chk("ch0 readback", 24'h001234, rd);
	endtask : t_readback

	task automatic t_gpio;
		i_host.xfer(cmd(1'b0, 4'h1, 3'h0, 16'h0006), 24, rd);
		settle();
		chk("gp enables", 24'h000001, {22'h0, gpPinOe});
		chk("gp values", 24'h000001, {22'h0, gpPinOut});
		@(posedge clock);
		extEn  <= 2'b10;
		extVal <= 2'b00;
		i_host.xfer(cmd(1'b1, 4'h1, 3'h0, 16'h0000), 24, rd);
		i_host.xfer(cmd(1'b1, 4'h1, 3'h0, 16'h0000), 24, rd);
		chk("gp read driven", 24'h000026, rd);
		@(posedge clock);
		extEn <= 2'b00;
		i_host.xfer(cmd(1'b1, 4'h1, 3'h0, 16'h0000), 24, rd);
		i_host.xfer(cmd(1'b1, 4'h1, 3'h0, 16'h0000), 24, rd);
		chk("gp read open", 24'h000066, rd);
	endtask : t_gpio

	task automatic t_daisy;
		i_host.xfer(cmd(1'b0, 4'h1, 3'h0, 16'h0007), 24, rd);
		i_host.xfer(cmd(1'b0, 4'h0, 3'h3, 16'hc3c3), 24, rd);
		i_host.xfer(cmd(1'b0, 4'h1, 3'h0, 16'h001e), 24, rd);
		chk("daisy echo", cmd(1'b0, 4'h0, 3'h3, 16'hc3c3), rd);
		i_host.xfer(cmd(1'b0, 4'h0, 3'h3, 16'hc3c3), 24, rd);
		chk("data out quiet", 24'h000000, rd);
		chk("ch3 loaded", 24'h00c3c3, {8'h00, chanValue[3]});
		chk("gp both enabled", 24'h000003, {22'h0, gpPinOe});
		chk("gp both high", 24'h000003, {22'h0, gpPinOut});
	endtask : t_daisy

	task automatic t_clear;
		@(posedge clock);
		clearN <= 1'b0;
		settle();
		for (int c = 0; c < 4; c++) begin
			chk("channel cleared", 24'h000000, {8'h00, chanValue[c]});
		end
		// A held low level must not keep clearing new writes.
		i_host.xfer(cmd(1'b0, 4'h0, 3'h3, 16'h0f0f), 24, rd);
		settle();
		chk("ch3 under low clear", 24'h000f0f, {8'h00, chanValue[3]});
		@(posedge clock);
		clearN <= 1'b1;
		settle();
		chk("ch3 after clear rise", 24'h000f0f, {8'h00, chanValue[3]});
		// The all-channels address writes every channel in one frame.
		i_host.xfer(cmd(1'b0, 4'h0, 3'h4, 16'h2468), 24, rd);
		settle();
		chk("ch0 all write", 24'h002468, {8'h00, chanValue[0]});
		chk("ch2 all write", 24'h002468, {8'h00, chanValue[2]});
	endtask : t_clear

	// ------------------------------------------------------------------------
	// Clock, sequence and watchdog
	// ------------------------------------------------------------------------
	initial begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end

	initial begin
		srst        = 1'b1;
		clearN      = 1'b1;
		loadStrobeN = 1'b1;
		extEn       = 2'b00;
		extVal      = 2'b00;
		nFail       = 0;
		nTests      = 0;
		repeat (16) @(posedge clock);
		srst <= 1'b0;
		settle();
		chk("ch0 after reset", 24'h000000, {8'h00, chanValue[0]});
		chk("gp enables after reset", 24'h000000, {22'h0, gpPinOe});
		t_immediate();
		t_deferred();
		t_refused();
		t_readback();
		t_gpio();
		t_daisy();
		t_clear();
		finish_test();
	end

	// About twenty frames of 1.4 us each; the limit leaves ample room.
	initial begin
		#200000;
		nFail++;
		finish_test();
	end

endmodule : tb
